// file: core/cmlr_pkg.sv
// Package of constants shared by the clock manager lock and reset model ends
package cmlr_pkg;
  // Default count of stable reference edges before lock is declared
  localparam int unsigned LOCK_COUNT_DEF   = 5000;
  // Extra multiplier on lock time when the synthesizer is enabled
  localparam int unsigned FS_LOCK_SCALE    = 4;
  // Lock indicator must fall within this many reference edges of reset
  localparam int unsigned RST_DROP_EDGES   = 4;
  // Reference period window, in clk cycles, counted as in limits
  localparam int unsigned REF_PER_MIN_DEF  = 2;
  localparam int unsigned REF_PER_MAX_DEF  = 64;
  // Width of the delay tap and phase offset values
  localparam int unsigned TAP_W            = 8;
  localparam logic [7:0]  TAP_RESET        = 8'h00;
  localparam logic [7:0]  PHASE_INIT_DEF   = 8'h00;
  // Least reset pulse time and the cycles it needs at 50 MHz
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned RST_MIN_NS       = 2;
  localparam int unsigned RST_MIN_CYC      =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reset sequencer hold length on the user side, in clk cycles
  localparam int unsigned USER_RST_HOLD    = 8;
  // Reference stable count needed by the user side before releasing reset
  localparam int unsigned USER_STABLE_EDGES = 16;
endpackage

// file: core/cmlr_if.sv
// Interface joining the clock manager model and its user-side logic
`timescale 1ns/1ps
`default_nettype none
interface cmlr_if;
  logic mgr_reset;      // Active-high manager reset from user logic
  logic lock;           // Lock indicator from the manager
  logic config_done;    // Configuration completion released by the manager
  logic ref_stable;     // Reference clock seen stable, from manager edge monitor
  modport manager (input mgr_reset, output lock, output config_done, output ref_stable);
  modport user    (output mgr_reset, input lock, input config_done, input ref_stable);
endinterface
`default_nettype wire

// file: core/cmlr_manager.sv
// Clock manager lock acquisition and reset behaviour model
//
// Function
// - Lock low after config and during reset
// - Always start acquiring after configuration
// - User holds reset until reference stable
// - Loop locks on aligned reference/feedback edges
// - Synthesizer locks on valid reference frequency
// - Lock takes thousands; synthesizer takes longer
// - Lock high when all enabled functions locked
// - User ignores output clocks while unlocked
// - Keep adjusting taps while reference in limits
// - Reference far out of limits drops lock
// - No automatic reacquire after losing lock
// - User resets manager on lock loss
// - Reset asynchronous, returns post-configuration state (model: state returns at the next clk edge; only lock drops at once)
// - Reset active high, at least 2 ns
// - User resets on reference frequency change
// - External feedback: hold reset after configuration
// - Lock drops within four reference cycles
// - Reset returns delay tap to zero
// - Reset restores initial phase offset
// - Optional hold of configuration until lock
`timescale 1ns/1ps
`default_nettype none
module cmlr_manager #(
  parameter int unsigned LOCK_COUNT  = cmlr_pkg::LOCK_COUNT_DEF,
  parameter int unsigned REF_PER_MIN = cmlr_pkg::REF_PER_MIN_DEF,
  parameter int unsigned REF_PER_MAX = cmlr_pkg::REF_PER_MAX_DEF,
  parameter logic [7:0]  PHASE_INIT  = cmlr_pkg::PHASE_INIT_DEF
) (
  // Clock and power-on reset (end of configuration)
  input  wire logic       clk,
  input  wire logic       resetn,
  // Sampled clock pins
  input  wire logic       reference_clock_in,
  input  wire logic       feedback_clock_in,
  // Options
  input  wire logic       hold_config_until_lock,
  input  wire logic       loop_enable,
  input  wire logic       synth_enable,
  // Status
  output logic [7:0]      delay_tap,
  output logic [7:0]      phase_offset,
  output logic            lost_lock,
  // Link to user side
  cmlr_if.manager         link
);
  // Parameter checks at time zero
  initial
  begin
    if (LOCK_COUNT < 1 || REF_PER_MIN < 1 || REF_PER_MAX <= REF_PER_MIN)
      $error("cmlr_manager: bad parameters");
  end

  localparam int unsigned CW = $clog2(LOCK_COUNT * cmlr_pkg::FS_LOCK_SCALE + 2);
  localparam int unsigned PW = $clog2(REF_PER_MAX + 2);

  typedef enum logic [1:0] {CMLR_ACQUIRE, CMLR_LOCKED, CMLR_LOST} cmlr_state_t;

  // Pin synchronisers; first stages are read only by second stages
  logic [1:0] ref_sync_reg;
  logic [1:0] fb_sync_reg;
  logic [1:0] rst_sync_reg;
  logic       ref_prev_reg;
  logic       fb_prev_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_sync_reg <= 2'h0;
      fb_sync_reg  <= 2'h0;
      rst_sync_reg <= 2'h0;
      ref_prev_reg <= 1'b0;
      fb_prev_reg  <= 1'b0;
    end
    else
    begin
      ref_sync_reg <= {ref_sync_reg[0], reference_clock_in};
      fb_sync_reg  <= {fb_sync_reg[0], feedback_clock_in};
      rst_sync_reg <= {rst_sync_reg[0], link.mgr_reset};
      ref_prev_reg <= ref_sync_reg[1];
      fb_prev_reg  <= fb_sync_reg[1];
    end
  end

  // Reference and feedback rising edges, and the sampled reset
  logic ref_rise;
  logic fb_rise;
  logic mrst;
  assign ref_rise = ref_sync_reg[1] & ~ref_prev_reg;
  assign fb_rise  = fb_sync_reg[1] & ~fb_prev_reg;
  // Raw pin also forces state so reset acts at the first clock edge it is high, ahead of the synchroniser
  assign mrst     = rst_sync_reg[1] | link.mgr_reset;

  // Lock state, counters and tap/phase registers
  cmlr_state_t     state_reg,  state_next;
  logic [CW-1:0]   cnt_reg,    cnt_next;
  logic [PW-1:0]   per_reg,    per_next;
  logic [7:0]      tap_reg,    tap_next;
  logic [7:0]      phase_reg,  phase_next;
  logic            fb_seen_reg, fb_seen_next;
  logic            per_good_reg, per_good_next;
  logic [CW-1:0]   target;
  logic            per_ok;
  logic            per_bad;

  // Synthesizer lock takes longer
  assign target  = synth_enable ? CW'(LOCK_COUNT * cmlr_pkg::FS_LOCK_SCALE) : CW'(LOCK_COUNT);
  // Reference period inside window means a valid frequency
  assign per_ok  = (per_reg >= PW'(REF_PER_MIN)) && (per_reg <= PW'(REF_PER_MAX));
  // Stall or far too fast counts as well out of limits
  assign per_bad = (per_reg > PW'(REF_PER_MAX)) || (ref_rise && per_reg < PW'(REF_PER_MIN));

  // Next-state logic for lock acquisition
  always_comb
  begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    tap_next     = tap_reg;
    phase_next   = phase_reg;
    fb_seen_next = fb_seen_reg;
    per_next     = ref_rise ? PW'(0) : (per_reg > PW'(REF_PER_MAX) ? per_reg : per_reg + PW'(1));
    // Last whole period in window; a stalled reference clears it
    per_good_next = ref_rise ? per_ok : (per_reg > PW'(REF_PER_MAX) ? 1'b0 : per_good_reg);
    if (fb_rise && !ref_rise)
      fb_seen_next = 1'b1;
    if (ref_rise)
      fb_seen_next = 1'b0;
    if (mrst)
    begin
      // Back to post-configuration state; resets tap and phase
      state_next   = CMLR_ACQUIRE;
      cnt_next     = '0;
      tap_next     = cmlr_pkg::TAP_RESET;
      phase_next   = PHASE_INIT;
      // Period monitor keeps running so the user can see the reference settle
      fb_seen_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        CMLR_ACQUIRE:
        begin
          // Acquire regardless of reference validity, except that synthesizer counts need per_ok
          if (ref_rise)
          begin
            // Loop alignment: feedback edge coincides with reference edge
            if ((!loop_enable || fb_rise) && (!synth_enable || per_ok))
              cnt_next = cnt_reg + CW'(1);
            else
            begin
              cnt_next = '0;
              // Step delay to pull feedback toward reference
              if (loop_enable)
                tap_next = fb_seen_reg ? tap_reg + 8'h01 : tap_reg - 8'h01;
            end
          end
          if (cnt_reg >= target)
            state_next = CMLR_LOCKED; // All enabled functions locked
        end
        CMLR_LOCKED:
        begin
          if (per_bad)
            state_next = CMLR_LOST;
          else if (ref_rise && loop_enable && !fb_rise)
            tap_next = fb_seen_reg ? tap_reg + 8'h01 : tap_reg - 8'h01;
        end
        CMLR_LOST:
          state_next = CMLR_LOST; // Waits for reset only
      endcase
    end
  end

  // State registers; power-on reset models end of configuration
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg   <= CMLR_ACQUIRE;
      cnt_reg     <= '0;
      per_reg     <= '0;
      tap_reg     <= cmlr_pkg::TAP_RESET;
      phase_reg   <= PHASE_INIT;
      fb_seen_reg <= 1'b0;
      per_good_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      per_reg     <= per_next;
      tap_reg     <= tap_next;
      phase_reg   <= phase_next;
      fb_seen_reg <= fb_seen_next;
      per_good_reg <= per_good_next;
    end
  end

  // Configuration completion register; released once and then held
  logic done_reg, done_next;
  always_comb
  begin
    done_next = done_reg | ~hold_config_until_lock | (state_reg == CMLR_LOCKED);
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      done_reg <= 1'b0;
    else
      done_reg <= done_next;
  end

  // Lock gated by raw reset: drops well inside four reference edges
  assign link.lock       = (state_reg == CMLR_LOCKED) & ~link.mgr_reset;
  assign link.config_done = done_reg;
  assign link.ref_stable = per_good_reg; // Steady level, not the running count
  assign delay_tap       = tap_reg;
  assign phase_offset    = phase_reg;
  assign lost_lock       = (state_reg == CMLR_LOST);
endmodule // cmlr_manager
`default_nettype wire

// file: core/cmlr_user.sv
// User-side reset sequencer driving the manager reset from lock status
`timescale 1ns/1ps
`default_nettype none
module cmlr_user #(
  parameter int unsigned HOLD_CYC     = cmlr_pkg::USER_RST_HOLD,
  parameter int unsigned STABLE_CYC   = cmlr_pkg::USER_STABLE_EDGES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // User controls
  input  wire logic external_feedback,
  input  wire logic freq_change,
  // User status
  output logic      clocks_valid,
  output logic      in_reset,
  // Link to manager
  cmlr_if.user      link
);
  initial
  begin
    if (HOLD_CYC < cmlr_pkg::RST_MIN_CYC || STABLE_CYC < 1)
      $error("cmlr_user: bad parameters");
  end

  localparam int unsigned HW = $clog2(HOLD_CYC + 1);
  localparam int unsigned SW = $clog2(STABLE_CYC + 1);

  typedef enum logic [1:0] {CMLU_WAIT_REF, CMLU_PULSE, CMLU_RUN} cmlr_seq_state_t;

  cmlr_seq_state_t state_reg, state_next;
  logic [HW-1:0] hold_reg,  hold_next;
  logic [SW-1:0] stab_reg,  stab_next;
  logic          lock_prev_reg;
  logic          rst_reg,   rst_next;

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    hold_next  = hold_reg;
    stab_next  = link.ref_stable ? (stab_reg == SW'(STABLE_CYC) ? stab_reg : stab_reg + SW'(1))
                                 : SW'(0);
    rst_next   = rst_reg;
    unique case (state_reg)
      CMLU_WAIT_REF:
      begin
        // Hold reset until reference stable; also covers external feedback
        rst_next = 1'b1;
        if (stab_reg == SW'(STABLE_CYC))
        begin
          state_next = CMLU_PULSE;
          hold_next  = HW'(HOLD_CYC);
        end
      end
      CMLU_PULSE:
      begin
        // Pulse far longer than the least reset width
        rst_next = 1'b1;
        if (!link.ref_stable)
          state_next = CMLU_WAIT_REF; // Reference wobbled; wait again
        else if (hold_reg == '0)
        begin
          state_next = CMLU_RUN;
          rst_next   = 1'b0;
        end
        else
          hold_next = hold_reg - HW'(1);
      end
      CMLU_RUN:
      begin
        // Lock fall or frequency change forces a reset
        if ((lock_prev_reg && !link.lock) || freq_change)
        begin
          state_next = CMLU_WAIT_REF;
          rst_next   = 1'b1;
        end
      end
    endcase
  end

  // Sequencer registers; reset held from power-on
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg     <= CMLU_WAIT_REF;
      hold_reg      <= '0;
      stab_reg      <= '0;
      lock_prev_reg <= 1'b0;
      rst_reg       <= 1'b1;
    end
    else
    begin
      state_reg     <= state_next;
      hold_reg      <= hold_next;
      stab_reg      <= stab_next;
      lock_prev_reg <= link.lock;
      rst_reg       <= rst_next;
    end
  end

  assign link.mgr_reset = rst_reg;
  // Output clocks only trusted while locked
  assign clocks_valid   = link.lock & ~rst_reg;
  assign in_reset       = rst_reg;
  // External feedback changes nothing here: reset is always held after configuration
  logic unused_ok;
  assign unused_ok = external_feedback;
endmodule // cmlr_user
`default_nettype wire

// file: sim/cmlr_link_asserts.sv
// Checker of lock and reset relations on the manager link
`timescale 1ns/1ps
`default_nettype none
module cmlr_link_chk #(
  parameter int unsigned LOCK_COUNT = cmlr_pkg::LOCK_COUNT_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link signals
  input wire logic mgr_reset,
  input wire logic lock,
  input wire logic config_done,
  input wire logic ref_stable
);
  logic [15:0] run_reg, run_next;
  logic        fell_reg, fell_next, lock_d_reg;
  // Cycles since reset release; lock loss not yet answered by a reset
  always_comb
  begin
    run_next  = mgr_reset ? 16'h0000 : run_reg + {15'h0000, run_reg != 16'hFFFF};
    fell_next = !mgr_reset && (fell_reg || (lock_d_reg && !lock));
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_reg    <= 16'h0000;
      fell_reg   <= 1'b0;
      lock_d_reg <= 1'b0;
    end
    else
    begin
      run_reg    <= run_next;
      fell_reg   <= fell_next;
      lock_d_reg <= lock;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_lost;
    $fell(lock) ##0 !mgr_reset;
  endsequence
  sequence s_release;
    $fell(mgr_reset);
  endsequence
  property p_lock_gated; mgr_reset |-> !lock; endproperty
  property p_lock_count; $rose(lock) |-> run_reg >= LOCK_COUNT; endproperty
  property p_lock_stable; $rose(lock) |-> ref_stable; endproperty
  property p_loss_cause; s_lost |-> !ref_stable || !$past(ref_stable); endproperty
  property p_no_reacquire; fell_reg |-> !lock; endproperty
  property p_user_react; s_lost |-> ##[0:1] mgr_reset; endproperty
  property p_reset_hold; $rose(mgr_reset) |-> mgr_reset [*8]; endproperty
  property p_release_ok; s_release |-> $past(ref_stable) && $past(ref_stable, 2); endproperty
  a_lock_gated: assert property (p_lock_gated) else $error("lock high in reset");
  a_lock_count: assert property (p_lock_count) else $error("lock too early");
  a_lock_stable: assert property (p_lock_stable) else $error("lock on bad ref");
  a_loss_cause: assert property (p_loss_cause) else $error("lock lost on good ref");
  a_no_reacquire: assert property (p_no_reacquire) else $error("relock w/o reset");
  a_user_react: assert property (p_user_react) else $error("no reset on loss");
  a_reset_hold: assert property (p_reset_hold) else $error("reset pulse short");
  a_release_ok: assert property (p_release_ok) else $error("release on bad ref");
  c_done: cover property ($rose(config_done));
endmodule // cmlr_link_chk
`default_nettype wire

// file: sim/tb_top.sv
// Testbench joining both ends of the clock manager link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LOCK_N = 8;
  localparam int REF_P  = 8;
  // Non-zero initial phase so that a restore is visible
  localparam logic [7:0] PHASE_I = 8'h3C;
  logic       clk, ref_in, fb_in, lost, clocks_valid, in_reset;
  logic       resetn = 1'b0, hold = 1'b1, loop_en = 1'b1, synth_en = 1'b0;
  logic       ext_fb = 1'b1, freq_chg = 1'b0, ref_run = 1'b1;
  logic [7:0] tap, phase;
  int         ph = 0, fb_ofs = 0, fails = 0, tests_run = 0;
  cmlr_if cmlr_if_inst ();
  cmlr_manager #(.LOCK_COUNT(LOCK_N), .PHASE_INIT(PHASE_I)) cmlr_manager_inst (.clk(clk),
    .resetn(resetn),
    .reference_clock_in(ref_in), .feedback_clock_in(fb_in), .hold_config_until_lock(hold),
    .loop_enable(loop_en), .synth_enable(synth_en), .delay_tap(tap), .phase_offset(phase),
    .lost_lock(lost), .link(cmlr_if_inst.manager));
  cmlr_user cmlr_user_inst (.clk(clk), .resetn(resetn), .external_feedback(ext_fb),
    .freq_change(freq_chg), .clocks_valid(clocks_valid), .in_reset(in_reset),
    .link(cmlr_if_inst.user));
  cmlr_link_chk #(.LOCK_COUNT(LOCK_N)) cmlr_link_chk_inst (.clk(clk), .resetn(resetn),
    .mgr_reset(cmlr_if_inst.mgr_reset), .lock(cmlr_if_inst.lock),
    .config_done(cmlr_if_inst.config_done), .ref_stable(cmlr_if_inst.ref_stable));
  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Reference and feedback; both stand low while stopped
  always @(negedge clk)
  begin
    ph     <= (ph + 1) % REF_P;
    ref_in <= ref_run && (ph < REF_P / 2);
    fb_in  <= ref_run && (((ph + fb_ofs) % REF_P) < REF_P / 2);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded wait for reset release, then count cycles until lock
  task automatic await_lock(output int n);
    int g;
    for (g = 0; g < 4000 && in_reset !== 1'b0; g++) @(negedge clk);
    for (n = 0; n < 4000 && cmlr_if_inst.lock !== 1'b1; n++) @(negedge clk);
    if (n == 4000 || g == 4000)
    begin
      fails++;
      end_of_test();
    end
  endtask
  // One-cycle frequency change request forces a fresh acquisition
  task automatic restart;
    freq_chg = 1'b1;
    @(negedge clk);
    freq_chg = 1'b0;
  endtask
  task automatic t_power_up;
    int n;
    check({in_reset, cmlr_if_inst.lock, cmlr_if_inst.config_done, 5'h00}, 8'h80);
    check(tap, cmlr_pkg::TAP_RESET);
    check(phase, PHASE_I);
    await_lock(n);
    check({7'h00, cmlr_if_inst.config_done}, 8'h00);
    @(negedge clk);
    check({7'h00, cmlr_if_inst.config_done}, 8'h01);
  endtask
  task automatic t_acquire(input logic l, input logic s);
    int n, cnt;
    loop_en = l;
    synth_en = s;
    restart();
    await_lock(n);
    cnt = s ? LOCK_N * int'(cmlr_pkg::FS_LOCK_SCALE) : LOCK_N;
    check({7'h00, n >= (cnt - 1) * REF_P && n <= (cnt + 2) * REF_P + 8}, 8'h01);
    check({7'h00, clocks_valid}, 8'h01);
  endtask
  // Leading feedback must never lock, but must move the taps
  task automatic t_misalign;
    fb_ofs = REF_P / 4;
    restart();
    repeat (60 * REF_P) @(negedge clk);
    check({7'h00, cmlr_if_inst.lock}, 8'h00);
    check({7'h00, tap !== cmlr_pkg::TAP_RESET}, 8'h01);
    fb_ofs = 0;
    restart();
    repeat (4) @(negedge clk);
    check(tap, cmlr_pkg::TAP_RESET);
    check(phase, PHASE_I);
  endtask
  // Reference stops: lock lost, user resets, relock once it returns
  task automatic t_loss;
    int g, n;
    ref_run = 1'b0;
    for (g = 0; g < 200 && cmlr_if_inst.lock !== 1'b0; g++) @(negedge clk);
    check({7'h00, g < REF_P + int'(cmlr_pkg::REF_PER_MAX_DEF) + 8}, 8'h01);
    check({7'h00, lost}, 8'h01);
    @(negedge clk);
    check({7'h00, in_reset}, 8'h01);
    repeat (200) @(negedge clk);
    check({6'h00, cmlr_if_inst.lock, clocks_valid}, 8'h00);
    ref_run = 1'b1;
    await_lock(n);
    check({7'h00, clocks_valid}, 8'h01);
  endtask
  // Configuration reset in mid-lock clears the indicator at once
  task automatic t_async;
    int n;
    resetn = 1'b0;
    #1;
    check({7'h00, cmlr_if_inst.lock}, 8'h00);
    hold = 1'b0;
    @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check({6'h00, cmlr_if_inst.config_done, cmlr_if_inst.lock}, 8'h02);
    await_lock(n);
    check({7'h00, clocks_valid}, 8'h01);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_power_up();
    t_acquire(1'b1, 1'b1);
    t_acquire(1'b0, 1'b1);
    t_acquire(1'b1, 1'b0);
    t_misalign();
    t_acquire(1'b1, 1'b0);
    t_loss();
    t_async();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
